// [rtl/ivq_defs.svh]
`ifndef IVQ_DEFS_SVH
`define IVQ_DEFS_SVH

// register offsets on the plain register port
`define IVQ_OFF_INDIRECT 8'hE0
`define IVQ_OFF_BASE     8'hE4
`define IVQ_OFF_LEN      8'hE8
`define IVQ_OFF_MASK     8'hEC
`define IVQ_OFF_WIDX     8'hF8

// indirect access register fields
`define IVQ_BIT_DEBUG    19
`define IVQ_BIT_MASK     18
`define IVQ_BIT_LEN      17
`define IVQ_BIT_BASE     16
`define IVQ_QSEL_HI      3
`define IVQ_LEN_HI       7
`define IVQ_BASE_LO      2

// queue numbers and sizes
`define IVQ_Q_HIPRI      4'h7
`define IVQ_Q_CMD        4'h8
`define IVQ_NUM_Q        9
`define IVQ_NUM_CHQ      8
`define IVQ_NUM_MASKQ    7
`define IVQ_LEN_UNIT     16
`define IVQ_LEN_ONE      8'hFF
`define IVQ_CMD_SIZE     13'h0200
`define IVQ_RESET_WORD   32'h00000000

`endif

// [rtl/ivq_pkg.sv]
package ivq_pkg;
  typedef logic [3:0]  ivq_qnum_t;
  typedef logic [12:0] ivq_idx_t;
  typedef logic [29:0] ivq_base_t;
  typedef logic [7:0]  ivq_len_t;
  typedef logic [31:0] ivq_word_t;
endpackage

// [rtl/ivq_route_if.sv]
interface ivq_route_if;
  import ivq_pkg::*;
  ivq_word_t data;
  ivq_word_t mask;
  logic [2:0] chan;
  logic       cmd;
  ivq_qnum_t  dest;
  modport core   (output data, output mask, output chan, output cmd, input dest);
  modport router (input data, input mask, input chan, input cmd, output dest);
endinterface

// [rtl/ivq_route.sv]
`include "ivq_defs.svh"
module ivq_route
  import ivq_pkg::*;
(
  ivq_route_if.router rt
);
  logic hit;

  always_comb begin
    hit = |(rt.data & rt.mask);
    if (rt.cmd) begin
      rt.dest = `IVQ_Q_CMD;
    end else if (hit) begin
      // forwarding wins over any unmasked bits in the same vector
      rt.dest = `IVQ_Q_HIPRI;
    end else begin
      rt.dest = {1'b0, rt.chan};
    end
  end
endmodule

// [rtl/ivq_wrptr.sv]
`include "ivq_defs.svh"
module ivq_wrptr
  import ivq_pkg::*;
#(
  parameter int IDX_W = 13
) (
  // clock and control
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             ce_in,
  // pointer control
  input  wire logic             clear_in,
  input  wire logic             adv_in,
  input  wire logic [IDX_W-1:0] size_in,
  // pointer
  output logic      [IDX_W-1:0] idx_out
);
  logic [IDX_W-1:0] idx_q;
  logic [IDX_W-1:0] idx_d;

  if (IDX_W < 13) begin : g_chk
    $error("ivq_wrptr: IDX_W too small for largest queue");
  end

  always_comb begin
    if (clear_in) begin
      idx_d = '0;
    end else if (adv_in) begin
      idx_d = (idx_q + 1'b1 >= size_in) ? '0 : idx_q + 1'b1;
    end else begin
      idx_d = idx_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      idx_q <= '0;
    end else if (ce_in) begin
      idx_q <= idx_d;
    end
  end

  assign idx_out = idx_q;

  a_ptr_in_range: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && adv_in && !clear_in && (idx_q + 1'b1 >= size_in) |=> idx_q == '0)
    else $error("write pointer did not wrap");
endmodule

// [rtl/ivq_core.sv]
`include "ivq_defs.svh"
// Summary of operation
// - base, length and mask strobes may commit together in one write.
// - command queue is fixed at 512 DWORD entries, not configurable.
// - length and mask commits to queue 8 are ignored.
// - mask commit to queue 7 is ignored; queue 7 vectors are never forwarded.
// - base addresses are DWORD aligned; low two bits read zero.
// - base change restarts that queue at its first location.
// - channel queue size is (field + 1) times 16 DWORDs.
// - field value 255 gives a one-DWORD queue, overriding the formula.
// - length change restarts that queue at its first location.
// - channel vectors normally go to their own channel queue 0 to 7.
// - high-priority destination is fixed as queue 7.
// - each of queues 0 to 6 keeps its own forwarding mask.
// - any vector bit matching its queue mask redirects to queue 7.
// - a mask match wins even when unmasked bits are also set.
// - strobes at bits 18, 17, 16; queue select at bits 3:0; zero is no-op.
// - queues 0 to 7 carry channel vectors; queue 8 carries command vectors.
// - debug bit copies active settings of selected queue into staging registers.
module ivq_core
  import ivq_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int VEC_W  = 32
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              ce_in,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [31:0]       reg_rdata_out,
  // interrupt vectors from the channel engines
  input  wire logic              vec_valid_in,
  input  wire logic              vec_cmd_in,
  input  wire logic [2:0]        vec_chan_in,
  input  wire logic [VEC_W-1:0]  vec_data_in,
  output logic                   vec_ready_out,
  // vector write towards shared memory
  output logic                   mem_valid_out,
  output logic      [31:0]       mem_addr_out,
  output logic      [VEC_W-1:0]  mem_data_out,
  output logic      [3:0]        mem_queue_out,
  input  wire logic              mem_ready_in
);
  if (VEC_W != 32 || ADDR_W < 8) begin : g_chk
    $error("ivq_core: vector width must be 32 and address width at least 8");
  end

  // staging and selection registers
  ivq_base_t stage_base_q;
  ivq_len_t  stage_len_q;
  ivq_word_t stage_mask_q;
  ivq_qnum_t qsel_q;

  // active per-queue settings
  ivq_base_t base_q [`IVQ_NUM_Q];
  ivq_len_t  len_q  [`IVQ_NUM_CHQ];
  ivq_word_t mask_q [`IVQ_NUM_MASKQ];

  // output stage
  logic      mem_valid_q;
  ivq_word_t mem_addr_q;
  ivq_word_t mem_data_q;
  ivq_qnum_t mem_queue_q;
  ivq_word_t rdata_q;

  // decoded writes
  logic      wr_ind;
  logic      wr_base;
  logic      wr_len;
  logic      wr_mask;
  logic      do_base;
  logic      do_len;
  logic      do_mask;
  logic      do_debug;
  ivq_qnum_t cq;
  logic      accept;
  ivq_word_t sel_mask;
  ivq_qnum_t dest;
  ivq_idx_t  idx    [`IVQ_NUM_Q];
  ivq_idx_t  qsize  [`IVQ_NUM_Q];

  function automatic ivq_idx_t len_size(input ivq_len_t l);
    if (l == `IVQ_LEN_ONE) begin
      len_size = 13'h0001;
    end else begin
      len_size = 13'(({5'h00, l} + 13'h0001) * `IVQ_LEN_UNIT);
    end
  endfunction

  assign wr_ind  = ce_in && reg_wr_in && reg_addr_in[7:0] == `IVQ_OFF_INDIRECT;
  assign wr_base = ce_in && reg_wr_in && reg_addr_in[7:0] == `IVQ_OFF_BASE;
  assign wr_len  = ce_in && reg_wr_in && reg_addr_in[7:0] == `IVQ_OFF_LEN;
  assign wr_mask = ce_in && reg_wr_in && reg_addr_in[7:0] == `IVQ_OFF_MASK;
  assign cq      = reg_wdata_in[`IVQ_QSEL_HI:0];

  // out-of-range queue numbers simply match nothing
  assign do_base  = wr_ind && reg_wdata_in[`IVQ_BIT_BASE] && cq <= `IVQ_Q_CMD;
  assign do_len   = wr_ind && reg_wdata_in[`IVQ_BIT_LEN] && cq < `IVQ_Q_CMD;
  assign do_mask  = wr_ind && reg_wdata_in[`IVQ_BIT_MASK] && cq < `IVQ_Q_HIPRI;
  // debug together with a strobe is refused so a commit never reads a half-copied stage
  assign do_debug = wr_ind && reg_wdata_in[`IVQ_BIT_DEBUG] && cq <= `IVQ_Q_CMD &&
                    !reg_wdata_in[`IVQ_BIT_MASK] && !reg_wdata_in[`IVQ_BIT_LEN] &&
                    !reg_wdata_in[`IVQ_BIT_BASE];

  // staging registers: software writes or debug copy-back
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      stage_base_q <= '0;
      stage_len_q  <= '0;
      stage_mask_q <= `IVQ_RESET_WORD;
    end else if (do_debug) begin
      stage_base_q <= base_q[cq];
      stage_len_q  <= (cq < `IVQ_Q_CMD) ? len_q[cq[2:0]] : '0;
      stage_mask_q <= (cq < `IVQ_Q_HIPRI) ? mask_q[cq[2:0]] : `IVQ_RESET_WORD;
    end else begin
      if (wr_base) begin
        stage_base_q <= reg_wdata_in[31:`IVQ_BASE_LO];
      end
      if (wr_len) begin
        stage_len_q <= reg_wdata_in[`IVQ_LEN_HI:0];
      end
      if (wr_mask) begin
        stage_mask_q <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      qsel_q <= '0;
    end else if (wr_ind) begin
      qsel_q <= cq;
    end
  end

  // commits; all three strobes may land in the same write
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < `IVQ_NUM_Q; i++) begin
        base_q[i] <= '0;
      end
    end else if (do_base) begin
      base_q[cq] <= stage_base_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < `IVQ_NUM_CHQ; i++) begin
        len_q[i] <= '0;
      end
    end else if (do_len) begin
      len_q[cq[2:0]] <= stage_len_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < `IVQ_NUM_MASKQ; i++) begin
        mask_q[i] <= `IVQ_RESET_WORD;
      end
    end else if (do_mask) begin
      mask_q[cq[2:0]] <= stage_mask_q;
    end
  end

  // vector routing
  ivq_route_if rt ();

  assign sel_mask = (vec_chan_in == 3'h7) ? `IVQ_RESET_WORD : mask_q[vec_chan_in];
  assign rt.data  = vec_data_in;
  assign rt.mask  = sel_mask;
  assign rt.chan  = vec_chan_in;
  assign rt.cmd   = vec_cmd_in;
  assign dest     = rt.dest;

  ivq_route u_route (
    .rt (rt)
  );

  // one-deep output stage; the memory side stalls the engines directly
  assign vec_ready_out = !mem_valid_q || mem_ready_in;
  assign accept        = ce_in && vec_valid_in && vec_ready_out;

  for (genvar q = 0; q < `IVQ_NUM_Q; q++) begin : g_ptr
    if (q == `IVQ_NUM_Q - 1) begin : g_cmd
      assign qsize[q] = `IVQ_CMD_SIZE;
    end else begin : g_ch
      assign qsize[q] = len_size(len_q[q]);
    end
    ivq_wrptr #(
      .IDX_W (13)
    ) u_ptr (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .ce_in     (ce_in),
      .clear_in  ((do_base || do_len) && cq == 4'(q)),
      .adv_in    (accept && dest == 4'(q)),
      .size_in   (qsize[q]),
      .idx_out   (idx[q])
    );
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mem_valid_q <= 1'b0;
      mem_addr_q  <= '0;
      mem_data_q  <= '0;
      mem_queue_q <= '0;
    end else if (ce_in) begin
      if (accept) begin
        mem_valid_q <= 1'b1;
        mem_addr_q  <= {base_q[dest] + 30'(idx[dest]), 2'b00};
        mem_data_q  <= vec_data_in;
        mem_queue_q <= dest;
      end else if (mem_ready_in) begin
        mem_valid_q <= 1'b0;
      end
    end
  end

  assign mem_valid_out = mem_valid_q;
  assign mem_addr_out  = mem_addr_q;
  assign mem_data_out  = mem_data_q;
  assign mem_queue_out = mem_queue_q;

  // read-back; strobes and debug are self-clearing and read as zero
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_q <= '0;
    end else if (ce_in && reg_rd_in) begin
      case (reg_addr_in[7:0])
        `IVQ_OFF_INDIRECT: rdata_q <= {28'h0000000, qsel_q};
        `IVQ_OFF_BASE:     rdata_q <= {stage_base_q, 2'b00};
        `IVQ_OFF_LEN:      rdata_q <= {24'h000000, stage_len_q};
        `IVQ_OFF_MASK:     rdata_q <= stage_mask_q;
        `IVQ_OFF_WIDX:     rdata_q <= (qsel_q <= `IVQ_Q_CMD) ? {19'h00000, idx[qsel_q]} : '0;
        default:           rdata_q <= '0;
      endcase
    end
  end

  assign reg_rdata_out = rdata_q;

  a_all_three: assert property (@(posedge clk_in) disable iff (!resetn_in)
    do_base && do_len && do_mask |=>
      base_q[$past(cq)] == stage_base_q && len_q[$past(cq[2:0])] == stage_len_q &&
      mask_q[$past(cq[2:0])] == stage_mask_q)
    else $error("joint commit did not apply all three values");

  // queue 8 shares its low select bits with queue 0, so slot 0 is the one at risk
  a_cmd_untouched: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_ind && cq == `IVQ_Q_CMD |=> $stable(len_q[0]) && $stable(mask_q[0]))
    else $error("queue 8 commit changed a channel setting");

  a_hipri_nomask: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept && !vec_cmd_in && vec_chan_in == 3'h7 |=> mem_queue_q == `IVQ_Q_HIPRI)
    else $error("queue 7 vector left queue 7");

  a_base_align: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && reg_rd_in && reg_addr_in[7:0] == `IVQ_OFF_BASE |=> reg_rdata_out[1:0] == 2'b00)
    else $error("base read-back not DWORD aligned");

  a_base_restart: assert property (@(posedge clk_in) disable iff (!resetn_in)
    do_base |=> idx[$past(cq)] == '0)
    else $error("base change did not restart queue");

  a_len_restart: assert property (@(posedge clk_in) disable iff (!resetn_in)
    do_len |=> idx[$past(cq)] == '0 ##1 1'b1)
    else $error("length change did not restart queue");

  a_regular_route: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept && !vec_cmd_in && (vec_data_in & sel_mask) == '0 |=>
      mem_queue_q == {1'b0, $past(vec_chan_in)})
    else $error("unmasked vector left its channel queue");

  a_fwd_hipri: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept && !vec_cmd_in && (vec_data_in & sel_mask) != '0 |=>
      mem_queue_q == `IVQ_Q_HIPRI && mem_valid_out)
    else $error("masked vector not forwarded");

  a_cmd_dest: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept && vec_cmd_in |=> mem_queue_q == `IVQ_Q_CMD)
    else $error("command vector not on queue 8");

  a_debug_copy: assert property (@(posedge clk_in) disable iff (!resetn_in)
    do_debug |=> stage_base_q == base_q[$past(cq)])
    else $error("debug copy did not load staged base");

  a_out_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    mem_valid_out && !mem_ready_in |=> mem_valid_out && $stable(mem_addr_out))
    else $error("memory write dropped while stalled");

  // a pointer past the queue end would scribble over whatever follows it in memory
  a_ptr_bound: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept |-> idx[dest] < qsize[dest])
    else $error("write pointer outside its queue");

  a_cmd_size: assert property (@(posedge clk_in) disable iff (!resetn_in)
    idx[`IVQ_Q_CMD] < `IVQ_CMD_SIZE)
    else $error("command queue pointer beyond its fixed size");

  a_len_one: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept && dest < `IVQ_Q_CMD && len_q[dest[2:0]] == `IVQ_LEN_ONE |=>
      idx[$past(dest)] == '0)
    else $error("one-entry queue did not stay at its first location");

  a_ready_stall: assert property (@(posedge clk_in) disable iff (!resetn_in)
    mem_valid_out && !mem_ready_in |-> !vec_ready_out)
    else $error("vector taken while memory write stalled");

  // a frozen block must not drift, or software reads settings it never wrote
  a_ce_freeze: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !ce_in |=> $stable(qsel_q) && $stable(stage_base_q) && $stable(mem_valid_out) &&
      $stable(reg_rdata_out))
    else $error("state moved while clock enable low");

  a_stage_base: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_base |=> stage_base_q == $past(reg_wdata_in[31:`IVQ_BASE_LO]))
    else $error("staged base not taken from the write");

  // main scenarios the bench is expected to reach
  c_forward: cover property (@(posedge clk_in) disable iff (!resetn_in)
    accept && dest == `IVQ_Q_HIPRI && vec_chan_in != 3'h7);
  c_joint: cover property (@(posedge clk_in) disable iff (!resetn_in)
    do_base && do_len && do_mask);
  c_stall: cover property (@(posedge clk_in) disable iff (!resetn_in)
    mem_valid_out && !mem_ready_in && vec_valid_in);
  c_wrap: cover property (@(posedge clk_in) disable iff (!resetn_in)
    accept && idx[dest] != '0 ##1 idx[$past(dest)] == '0);
  c_debug: cover property (@(posedge clk_in) disable iff (!resetn_in)
    do_debug);
endmodule

// [tb/ivq_mem_model.sv]
module ivq_mem_model
  import ivq_pkg::*;
(
  // clock
  input  wire logic        clk_in,
  // vector write from the block
  input  wire logic        valid_in,
  input  wire logic [31:0] addr_in,
  input  wire ivq_word_t   data_in,
  input  wire logic [3:0]  queue_in,
  output logic             ready_out,
  // pacing and observation
  input  wire logic        slow_in,
  output int               count_out,
  output logic [31:0]      addr_out,
  output ivq_word_t        data_out,
  output logic [3:0]       queue_out
);
  logic phase_q = 1'b0;
  int   cnt_q   = 0;
  // slow memory takes a write only every other cycle, so stalls hit both phases
  assign ready_out = !slow_in || phase_q;
  assign count_out = cnt_q;
  always_ff @(posedge clk_in) begin
    phase_q <= !phase_q;
    if (valid_in && ready_out) begin
      cnt_q     <= cnt_q + 1;
      addr_out  <= addr_in;
      data_out  <= data_in;
      queue_out <= queue_in;
    end
  end
endmodule

// [tb/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ivq_pkg::*;
  logic        clk_in       = 1'b0;
  logic        resetn_in    = 1'b0;
  logic        ce_in        = 1'b1;
  logic [7:0]  reg_addr_in  = 8'h00;
  ivq_word_t   reg_wdata_in = 32'h0;
  logic        reg_wr_in    = 1'b0;
  logic        reg_rd_in    = 1'b0;
  logic        vec_valid_in = 1'b0;
  logic        vec_cmd_in   = 1'b0;
  logic [2:0]  vec_chan_in  = 3'h0;
  ivq_word_t   vec_data_in  = 32'h0;
  logic        slow         = 1'b0;
  ivq_word_t   reg_rdata_out;
  logic        vec_ready_out;
  logic        mem_valid_out;
  logic [31:0] mem_addr_out;
  ivq_word_t   mem_data_out;
  logic [3:0]  mem_queue_out;
  logic        mem_ready_in;
  int          mcount;
  logic [31:0] maddr;
  ivq_word_t   mdata;
  logic [3:0]  mq;
  int          errors = 0;
  int          checks = 0;
  logic [31:0] base_m [9];
  logic [31:0] mask_m [9];
  int          size_m [9];
  int          idx_m [9];
  ivq_word_t   st_b;
  ivq_word_t   st_m;
  logic [7:0]  st_l;

  ivq_core uut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .vec_valid_in(vec_valid_in), .vec_cmd_in(vec_cmd_in), .vec_chan_in(vec_chan_in),
    .vec_data_in(vec_data_in), .vec_ready_out(vec_ready_out), .mem_valid_out(mem_valid_out),
    .mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out), .mem_queue_out(mem_queue_out),
    .mem_ready_in(mem_ready_in));
  ivq_mem_model mem (.clk_in(clk_in), .valid_in(mem_valid_out), .addr_in(mem_addr_out),
    .data_in(mem_data_out), .queue_in(mem_queue_out), .ready_out(mem_ready_in), .slow_in(slow),
    .count_out(mcount), .addr_out(maddr), .data_out(mdata), .queue_out(mq));

  initial begin
    forever #5 clk_in = !clk_in;
  end

  task automatic test_done;
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask

  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input ivq_word_t d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [7:0] a, input ivq_word_t e);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk("read data", e, reg_rdata_out);
    @(posedge clk_in);
  endtask

  task automatic stage(input ivq_word_t b, input logic [7:0] l, input ivq_word_t m);
    wr(8'hE4, b);
    wr(8'hE8, {24'h0, l});
    wr(8'hEC, m);
    st_b = b;
    st_l = l;
    st_m = m;
  endtask

  // f holds the mask, length and base strobes, high to low
  task automatic commit(input int q, input logic [2:0] f);
    wr(8'hE0, {13'h0, f, 12'h0, 4'(q)});
    if (f[0]) begin
      base_m[q] = st_b & 32'hFFFFFFFC;
      idx_m[q]  = 0;
    end
    if (f[1] && q < 8) begin
      size_m[q] = (st_l == 8'hFF) ? 1 : (int'(st_l) + 1) * 16;
      idx_m[q]  = 0;
    end
    if (f[2] && q < 7) mask_m[q] = st_m;
  endtask

  task automatic vec(input logic c, input logic [2:0] ch, input ivq_word_t d);
    int q;
    int n;
    int k;
    q = c ? 8 : ((ch != 3'h7 && |(d & mask_m[ch])) ? 7 : int'(ch));
    n = mcount;
    vec_valid_in <= 1'b1;
    vec_cmd_in   <= c;
    vec_chan_in  <= ch;
    vec_data_in  <= d;
    @(negedge clk_in);
    for (k = 0; k < 50 && vec_ready_out !== 1'b1; k++) @(negedge clk_in);
    @(posedge clk_in);
    vec_valid_in <= 1'b0;
    for (k = 0; k < 50 && mcount == n; k++) @(negedge clk_in);
    chk("mem queue", 32'(q), {28'h0, mq});
    chk("mem addr", base_m[q] + 32'(idx_m[q] * 4), maddr);
    chk("mem data", d, mdata);
    idx_m[q] = (idx_m[q] + 1) % size_m[q];
    @(posedge clk_in);
  endtask

  initial begin
    for (int i = 0; i < 9; i++) begin
      base_m[i] = 32'h0;
      mask_m[i] = 32'h0;
      idx_m[i]  = 0;
      size_m[i] = (i == 8) ? 512 : 16;
    end
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    chk("ready after reset", 32'h1, {31'h0, vec_ready_out});
    chk("valid after reset", 32'h0, {31'h0, mem_valid_out});
    @(posedge clk_in);
    rd(8'hE4, 32'h0);
    rd(8'hE8, 32'h0);
    rd(8'hEC, 32'h0);
    rd(8'h40, 32'h0);
    stage(32'h00001003, 8'hFF, 32'h00000001);
    rd(8'hE4, 32'h00001000);
    commit(4, 3'b111);
    vec(1'b0, 3'h4, 32'h2);
    vec(1'b0, 3'h4, 32'h4);
    vec(1'b0, 3'h4, 32'h3);
    vec(1'b0, 3'h1, 32'h1);
    slow <= 1'b1;
    stage(32'h00002000, 8'h00, 32'h0);
    commit(5, 3'b011);
    for (int i = 0; i < 18; i++) vec(1'b0, 3'h5, 32'(i));
    commit(5, 3'b001);
    vec(1'b0, 3'h5, 32'hA5);
    stage(32'h00002000, 8'h01, 32'h0);
    commit(5, 3'b010);
    vec(1'b0, 3'h5, 32'h5A);
    slow <= 1'b0;
    for (int i = 0; i < 8; i++) vec(1'b0, 3'(i), 32'h0);
    stage(32'h00003000, 8'h05, 32'hFFFFFFFF);
    commit(8, 3'b110);
    commit(7, 3'b100);
    commit(8, 3'b001);
    vec(1'b0, 3'h7, 32'h1);
    vec(1'b0, 3'h0, 32'h1);
    for (int i = 0; i < 513; i++) vec(1'b1, 3'h3, 32'(i));
    wr(8'hE4, 32'h0000F000);
    wr(8'hE0, 32'h00080008);
    rd(8'hE4, 32'h00003000);
    rd(8'hE8, 32'h0);
    rd(8'hEC, 32'h0);
    rd(8'hE0, 32'h00000008);
    rd(8'hF8, 32'(idx_m[8]));
    wr(8'hE0, 32'h00080007);
    rd(8'hEC, 32'h0);
    wr(8'hE0, 32'h00080004);
    rd(8'hE4, 32'h00001000);
    rd(8'hE8, 32'h000000FF);
    rd(8'hEC, 32'h00000001);
    ce_in <= 1'b0;
    wr(8'hE4, 32'h00005550);
    ce_in <= 1'b1;
    rd(8'hE4, 32'h00001000);
    test_done();
  end

  // the sequence needs roughly 1750 cycles
  initial begin
    #200000;
    errors++;
    test_done();
  end
endmodule
